/* File: hdl/gcd_pkg.sv */
// Behaviour
// - Bytes taken with attention true are commands or addresses, not data.
// - Bytes taken with attention false go to the instrument as characters.
// - Attention, clear and remote enable lines are watched, never driven.
// - Service request, once raised, is held until the device is served or cleared.
// - End-or-identify on a data byte marks it as the last character.
// - Interface clear drops both listener and talker addressed states.
// - Remote enable going true puts the device in remote operation.
// - Universal commands act whether or not the device is addressed.
// - Local lockout code disables the front panel controls.
// - Device clear code returns the device to power-up conditions.
// - Serial poll enable enters serial poll mode; disable leaves it.
// - Addressed commands are ignored unless addressed to listen.
// - Selective device clear resets only a device addressed to listen.
// - Go-to-local while addressed to listen leaves remote mode.
// - Group execute trigger while addressed to listen starts the configured action.
// - Unlisten with attention true enters listener idle.
// - Untalk with attention true enters talker idle.
// - Listen group codes are compared with the own listen address.
// - Talk group codes equal to the own talk address make it talker.
// - Secondary group codes never change the addressing state.
// - Only the low seven data lines are decoded for commands.
// - Data characters are kept in order as an instrument command string.
// - Primary address 0 to 30; listen adds hex 20, talk adds hex 40.
// - Each byte is taken only through the interlocked handshake.
`default_nettype none
package gcd_pkg;

    // Multiline command codes, seven bits wide.
    localparam logic [6:0] GCD_GTL = 7'h01;
    localparam logic [6:0] GCD_SDC = 7'h04;
    localparam logic [6:0] GCD_GET = 7'h08;
    localparam logic [6:0] GCD_LLO = 7'h11;
    localparam logic [6:0] GCD_DCL = 7'h14;
    localparam logic [6:0] GCD_SPE = 7'h18;
    localparam logic [6:0] GCD_SPD = 7'h19;
    localparam logic [6:0] GCD_UNL = 7'h3F;
    localparam logic [6:0] GCD_UNT = 7'h5F;

    // Group bases and the mask that selects the group bits.
    localparam logic [6:0] GCD_LAG_BASE = 7'h20;
    localparam logic [6:0] GCD_TAG_BASE = 7'h40;
    localparam logic [6:0] GCD_SCG_BASE = 7'h60;
    localparam logic [6:0] GCD_GRP_MASK = 7'h60;
    localparam logic [4:0] GCD_PA_MAX   = 5'h1E;

    // Character buffer depth toward the instrument parser.
    localparam int GCD_FIFO_DEPTH = 16;

    // Acceptor handshake states, one bit apart from ready to accept to done.
    typedef enum logic [1:0] {
        GCD_HS_RDY  = 2'h0,
        GCD_HS_ACPT = 2'h1,
        GCD_HS_DONE = 2'h3
    } gcd_hs_t;

    // Bus lines after inversion to active high, plus the address switches.
    typedef struct packed {
        logic       atn;
        logic       ifc;
        logic       ren;
        logic       eoi;
        logic       dav;
        logic [7:0] dio;
        logic [4:0] pa;
    } gcd_pins_t;

    // One character for the instrument, with its end marker.
    typedef struct packed {
        logic       eoi;
        logic [7:0] chr;
    } gcd_chr_t;

    localparam int GCD_CHR_W = $bits(gcd_chr_t);

    // Complete state of the decoder.
    typedef struct packed {
        gcd_pins_t  s1;
        gcd_pins_t  s2;
        gcd_hs_t    hs;
        logic [7:0] byte_q;
        logic       eoi_q;
        logic       cmd_q;
        logic       listen;
        logic       talk;
        logic       remote;
        logic       lockout;
        logic       spoll;
        logic       ren_q;
        logic       trig;
        logic       clr;
        logic       nrfd_oe_n;
        logic       ndac_oe_n;
        logic       srq_oe_n;
    } gcd_state_t;

    localparam gcd_state_t GCD_ST_RST = '{
        hs:        GCD_HS_RDY,
        nrfd_oe_n: 1'b1,
        ndac_oe_n: 1'b1,
        srq_oe_n:  1'b1,
        default:   '0
    };

endpackage : gcd_pkg
`default_nettype wire

/* File: hdl/gcd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

// Character FIFO with a registered output stage.
module gcd_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic [W-1:0]            oreg;
        logic                    ovld;
    } gcd_fifo_st_t;

    gcd_fifo_st_t st;
    gcd_fifo_st_t nxt_st;
    logic         push;
    logic         pop;
    logic         take;

    // Pointers wrap naturally, so DEPTH must be a power of two.
    always_comb begin
        nxt_st = st;
        push   = in_valid_i && in_ready_o;
        pop    = st.ovld && out_ready_i;
        take   = (st.cnt != '0) && (!st.ovld || pop);
        if (push) begin
            nxt_st.mem[st.wp] = in_data_i;
            nxt_st.wp         = st.wp + AW'(1);
        end
        if (take) begin
            nxt_st.oreg = st.mem[st.rp];
            nxt_st.rp   = st.rp + AW'(1);
            nxt_st.ovld = 1'b1;
        end else if (pop) begin
            nxt_st.ovld = 1'b0;
        end
        nxt_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
    end

    // Synchronous reset empties the buffer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= nxt_st;
        end
    end

    // Full is honest: the output register is extra room, not counted.
    assign in_ready_o  = st.cnt < (AW+1)'(DEPTH);
    assign out_valid_o = st.ovld;
    assign out_data_o  = st.oreg;

endmodule : gcd_fifo

// Command layer decoder for the instrument bus acceptor side.
module gcd_decoder
    import gcd_pkg::*;
#(
    parameter int DEPTH = gcd_pkg::GCD_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       dio_n_i,
    input  wire logic             atn_n_i,
    input  wire logic             ifc_n_i,
    input  wire logic             ren_n_i,
    input  wire logic             eoi_n_i,
    input  wire logic             dav_n_i,
    input  wire logic [4:0]       pa_i,
    input  wire logic             svc_req_i,
    output logic                  nrfd_out_o,
    output logic                  nrfd_oe_n_o,
    output logic                  ndac_out_o,
    output logic                  ndac_oe_n_o,
    output logic                  srq_out_o,
    output logic                  srq_oe_n_o,
    output var gcd_pkg::gcd_chr_t chr_o,
    output logic                  chr_valid_o,
    input  wire logic             chr_ready_i,
    output logic                  listen_o,
    output logic                  talk_o,
    output logic                  remote_o,
    output logic                  lockout_o,
    output logic                  spoll_o,
    output logic                  trigger_o,
    output logic                  dev_clear_o
);
    import gcd_pkg::*;

    gcd_state_t st;
    gcd_state_t nxt_st;
    gcd_pins_t  pins;
    gcd_chr_t   push_chr;
    logic       push;
    logic       fifo_rdy;
    logic [6:0] code;

    // Compares a command with the own address in one group.
    function automatic logic own_adr(input logic [6:0] c,
                                     input logic [6:0] base,
                                     input logic [4:0] pa);
        own_adr = (pa <= GCD_PA_MAX) && (c == {base[6:5], pa});
    endfunction : own_adr

    // Bus lines are active low; invert once at the edge of the block.
    assign pins = '{
        atn: ~atn_n_i,
        ifc: ~ifc_n_i,
        ren: ~ren_n_i,
        eoi: ~eoi_n_i,
        dav: ~dav_n_i,
        dio: ~dio_n_i,
        pa:  pa_i
    };

    // The top data line is dropped for every command decision.
    assign code     = st.byte_q[6:0];
    assign push_chr = '{eoi: st.eoi_q, chr: st.byte_q};

    // Next state: synchroniser, handshake, decode, then uniline overrides.
    always_comb begin
        nxt_st      = st;
        push        = 1'b0;
        nxt_st.s1   = pins;
        nxt_st.s2   = st.s1;
        nxt_st.trig = 1'b0;
        nxt_st.clr  = 1'b0;
        case (st.hs)
            GCD_HS_RDY: begin
                if (!st.s2.atn && !st.listen) begin
                    // Not a listener: stay out of the data handshake.
                    nxt_st.nrfd_oe_n = 1'b1;
                    nxt_st.ndac_oe_n = 1'b1;
                end else if (st.s2.dav && st.nrfd_oe_n
                             && !st.ndac_oe_n) begin
                    nxt_st.byte_q    = st.s2.dio;
                    nxt_st.eoi_q     = st.s2.eoi;
                    nxt_st.cmd_q     = st.s2.atn;
                    nxt_st.nrfd_oe_n = 1'b0;
                    nxt_st.hs        = GCD_HS_ACPT;
                end else begin
                    // Ready is withheld while the character buffer is full.
                    nxt_st.ndac_oe_n = 1'b0;
                    nxt_st.nrfd_oe_n = fifo_rdy && !st.s2.dav;
                end
            end
            GCD_HS_ACPT: begin
                if (!st.cmd_q) begin
                    push = st.listen;
                end else if (code == GCD_UNL) begin
                    nxt_st.listen = 1'b0;
                end else if (code == GCD_UNT) begin
                    nxt_st.talk = 1'b0;
                end else if ((code & GCD_GRP_MASK) == GCD_LAG_BASE) begin
                    if (own_adr(code, GCD_LAG_BASE, st.s2.pa)) begin
                        nxt_st.listen = 1'b1;
                    end
                end else if ((code & GCD_GRP_MASK) == GCD_TAG_BASE) begin
                    // Another device's talk address retires this talker.
                    nxt_st.talk = own_adr(code, GCD_TAG_BASE,
                                          st.s2.pa);
                end else if ((code & GCD_GRP_MASK) == GCD_SCG_BASE) begin
                    nxt_st.listen = st.listen;
                end else begin
                    case (code)
                        GCD_LLO: nxt_st.lockout = 1'b1;
                        GCD_DCL: nxt_st.clr     = 1'b1;
                        GCD_SPE: nxt_st.spoll   = 1'b1;
                        GCD_SPD: nxt_st.spoll   = 1'b0;
                        GCD_GTL: begin
                            if (st.listen) begin
                                nxt_st.remote = 1'b0;
                            end
                        end
                        GCD_SDC: nxt_st.clr  = st.listen;
                        GCD_GET: nxt_st.trig = st.listen;
                        default: nxt_st.clr  = 1'b0;
                    endcase
                end
                nxt_st.ndac_oe_n = 1'b1;
                nxt_st.hs        = GCD_HS_DONE;
            end
            GCD_HS_DONE: begin
                if (!st.s2.dav) begin
                    nxt_st.ndac_oe_n = 1'b0;
                    nxt_st.hs        = GCD_HS_RDY;
                end
            end
            default: begin
                nxt_st.hs = GCD_HS_RDY;
            end
        endcase

        // Remote follows the rising edge of the watched enable line.
        nxt_st.ren_q = st.s2.ren;
        if (st.s2.ren && !st.ren_q) begin
            nxt_st.remote = 1'b1;
        end
        if (!st.s2.ren) begin
            nxt_st.remote  = 1'b0;
            nxt_st.lockout = 1'b0;
        end

        // Interface clear wins over any address byte in the same cycle.
        if (st.s2.ifc) begin
            nxt_st.listen = 1'b0;
            nxt_st.talk   = 1'b0;
        end

        // Being polled as talker counts as served; a new request wins.
        if (st.spoll && st.talk) begin
            nxt_st.srq_oe_n = 1'b1;
        end
        if (st.clr) begin
            nxt_st.srq_oe_n = 1'b1;
        end
        if (svc_req_i) begin
            nxt_st.srq_oe_n = 1'b0;
        end
    end

    // One register holds the whole decoder state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= GCD_ST_RST;
        end else begin
            st <= nxt_st;
        end
    end

    // Characters wait here until the instrument parser takes them.
    gcd_fifo #(
        .W     (GCD_CHR_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (push_chr),
        .out_valid_o (chr_valid_o),
        .out_ready_i (chr_ready_i),
        .out_data_o  (chr_o)
    );

    // Open-drain lines only ever pull low; the enable decides.
    assign nrfd_out_o  = 1'b0;
    assign ndac_out_o  = 1'b0;
    assign srq_out_o   = 1'b0;
    assign nrfd_oe_n_o = st.nrfd_oe_n;
    assign ndac_oe_n_o = st.ndac_oe_n;
    assign srq_oe_n_o  = st.srq_oe_n;
    assign listen_o    = st.listen;
    assign talk_o      = st.talk;
    assign remote_o    = st.remote;
    assign lockout_o   = st.lockout;
    assign spoll_o     = st.spoll;
    assign trigger_o   = st.trig;
    assign dev_clear_o = st.clr;

    // Checks run on the single clock and pause during reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic acpt_cmd;
    assign acpt_cmd = (st.hs == GCD_HS_ACPT) && st.cmd_q && !st.s2.ifc;

    chk_atn_no_data: assert property (
        (st.hs == GCD_HS_ACPT) && st.cmd_q |-> !push)
        else $error("command byte was pushed as data");
    chk_data_forward: assert property (
        (st.hs == GCD_HS_ACPT) && !st.cmd_q && st.listen
        |-> push ##1 st.hs == GCD_HS_DONE)
        else $error("listened data byte not forwarded");
    chk_ifc_idle: assert property (
        st.s2.ifc |=> !listen_o && !talk_o)
        else $error("interface clear left device addressed");
    chk_unl_idle: assert property (
        acpt_cmd && code == GCD_UNL |=> !listen_o)
        else $error("unlisten ignored");
    chk_unt_idle: assert property (
        acpt_cmd && code == GCD_UNT |=> !talk_o)
        else $error("untalk ignored");
    chk_lag_match: assert property (
        acpt_cmd && st.s2.pa <= GCD_PA_MAX
        && code == (GCD_LAG_BASE | {2'b00, st.s2.pa}) |=> listen_o)
        else $error("own listen address missed");
    chk_tag_match: assert property (
        acpt_cmd && (code & GCD_GRP_MASK) == GCD_TAG_BASE
        |=> talk_o == (code[4:0] == $past(st.s2.pa)
                       && $past(st.s2.pa) <= GCD_PA_MAX))
        else $error("talk address compare wrong");
    chk_scg_keep: assert property (
        acpt_cmd && (code & GCD_GRP_MASK) == GCD_SCG_BASE
        |=> $stable(listen_o) && $stable(talk_o))
        else $error("secondary code changed addressing");
    chk_llo_lock: assert property (
        acpt_cmd && code == GCD_LLO && st.s2.ren |=> lockout_o)
        else $error("local lockout not applied");
    chk_dcl_clear: assert property (
        acpt_cmd && code == GCD_DCL |=> dev_clear_o ##1 !dev_clear_o)
        else $error("device clear pulse wrong");
    chk_sdc_unaddr: assert property (
        acpt_cmd && !st.listen && code != GCD_DCL |=> !dev_clear_o)
        else $error("unaddressed device cleared");
    chk_get_trig: assert property (
        acpt_cmd && code == GCD_GET && st.listen |=> trigger_o)
        else $error("trigger not issued");
    chk_spoll_mode: assert property (
        acpt_cmd && code == GCD_SPD |=> !spoll_o)
        else $error("serial poll not left");
    chk_srq_hold: assert property (
        !srq_oe_n_o && !(st.spoll && st.talk) && !st.clr |=> !srq_oe_n_o)
        else $error("service request dropped early");
    chk_srq_raise: assert property (
        svc_req_i |=> !srq_oe_n_o)
        else $error("service request not raised");

    // Ready stays withheld for the whole transfer, so a source can never
    // start the next byte before this one has been acknowledged.
    chk_nrfd_held: assert property (
        st.hs != GCD_HS_RDY |-> !nrfd_oe_n_o)
        else $error("ready released during a transfer");
    chk_ndac_after: assert property (
        st.hs == GCD_HS_ACPT |=> ndac_oe_n_o && st.hs == GCD_HS_DONE)
        else $error("byte not acknowledged after capture");
    chk_ren_remote: assert property (
        st.s2.ren && !st.ren_q |=> remote_o)
        else $error("remote enable did not set remote");
    chk_gtl_local: assert property (
        acpt_cmd && code == GCD_GTL && st.listen
        && !(st.s2.ren && !st.ren_q) |=> !remote_o)
        else $error("go to local ignored");
    chk_gtl_keep: assert property (
        acpt_cmd && code == GCD_GTL && !st.listen
        && st.s2.ren && st.ren_q |=> $stable(remote_o))
        else $error("unaddressed device went local");
    chk_get_unaddr: assert property (
        acpt_cmd && code == GCD_GET && !st.listen |=> !trigger_o)
        else $error("unaddressed device triggered");
    chk_sdc_listen: assert property (
        acpt_cmd && code == GCD_SDC && st.listen |=> dev_clear_o)
        else $error("selective clear ignored");
    chk_listen_keep: assert property (
        listen_o && !st.s2.ifc && !(acpt_cmd && code == GCD_UNL)
        |=> listen_o)
        else $error("listener state lost without unlisten");

    // Main scenarios: addressing then data, stall, poll, end marker, clear.

    cov_addr_data: cover property (
        acpt_cmd && code[6:5] == 2'b01 ##[1:200] push);
    cov_full_stall: cover property (!fifo_rdy && st.listen);
    cov_poll: cover property (spoll_o && talk_o && !srq_oe_n_o);
    cov_eoi_char: cover property (push && st.eoi_q);
    cov_sdc_clear: cover property (dev_clear_o && listen_o);

endmodule : gcd_decoder
`default_nettype wire

/* File: verif/gcd_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Behavioural bus controller that sources every byte and owns the lines.
module gcd_ctl_model (
    input  wire logic  clk_i,
    input  wire logic  nrfd_i,
    input  wire logic  ndac_i,
    output logic [7:0] dio_n_o,
    output logic       atn_n_o,
    output logic       ifc_n_o,
    output logic       ren_n_o,
    output logic       eoi_n_o,
    output logic       dav_n_o
);
    // Released lines sit at the pull-up level, so everything starts high.
    initial begin
        dio_n_o = 8'hFF;
        atn_n_o = 1'b1;
        ifc_n_o = 1'b1;
        ren_n_o = 1'b1;
        eoi_n_o = 1'b1;
        dav_n_o = 1'b1;
    end

    // Sources one byte. The waits are bounded so that a silent acceptor
    // returns ok low instead of hanging the bus.
    task automatic xfer(input logic atn, input logic eoi,
                        input logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clk_i);
        #1;
        atn_n_o = ~atn;
        dio_n_o = ~b;
        eoi_n_o = ~eoi;
        // Ready is judged at an edge, so the strobe always follows one.
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (n < 40 && !(nrfd_i && !ndac_i));
        if (nrfd_i && !ndac_i) begin
            #1 dav_n_o = 1'b0;
            for (n = 0; n < 40 && !ndac_i; n++) @(posedge clk_i);
            ok = ndac_i;
            #1 dav_n_o = 1'b1;
        end
        dio_n_o = 8'hFF;
        eoi_n_o = 1'b1;
    endtask : xfer

    // Remote enable and interface clear are driven only from here.
    task automatic lines(input logic ren, input logic ifc);
        @(posedge clk_i);
        #1;
        ren_n_o = ~ren;
        ifc_n_o = ~ifc;
    endtask : lines
endmodule : gcd_ctl_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import gcd_pkg::*;
    logic       clk_i = 1'b0, rst_i = 1'b1, svc_req_i = 1'b0;
    logic       chr_ready_i = 1'b0, rnd_en = 1'b1;
    logic [4:0] pa_i = 5'h1B;
    wire  [7:0] dio_n_i;
    wire        atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i;
    logic       nrfd_out_o, nrfd_oe_n_o, ndac_out_o, ndac_oe_n_o;
    logic       srq_out_o, srq_oe_n_o, chr_valid_o, listen_o, talk_o;
    logic       remote_o, lockout_o, spoll_o, trigger_o, dev_clear_o;
    gcd_chr_t   chr_o;
    gcd_chr_t   exp_q[$];
    int         failures = 0, n_checks = 0, n_trig = 0, n_clr = 0;
    integer     seed = 50;
    logic [4:0] st;

    // Open-drain wires: a released line floats to the pull-up level.
    wire nrfd_w = nrfd_oe_n_o ? 1'b1 : nrfd_out_o;
    wire ndac_w = ndac_oe_n_o ? 1'b1 : ndac_out_o;
    wire [2:0] oe_w = {nrfd_oe_n_o, ndac_oe_n_o, srq_oe_n_o};
    assign st = {listen_o, talk_o, remote_o, lockout_o, spoll_o};

    always #2.5 clk_i = ~clk_i;

    gcd_decoder #(.DEPTH(4)) DUT (
        .clk_i, .rst_i, .dio_n_i, .atn_n_i, .ifc_n_i, .ren_n_i, .eoi_n_i,
        .dav_n_i, .pa_i, .svc_req_i, .nrfd_out_o, .nrfd_oe_n_o,
        .ndac_out_o, .ndac_oe_n_o, .srq_out_o, .srq_oe_n_o, .chr_o,
        .chr_valid_o, .chr_ready_i, .listen_o, .talk_o, .remote_o,
        .lockout_o, .spoll_o, .trigger_o, .dev_clear_o
    );

    gcd_ctl_model ctl (
        .clk_i   (clk_i),
        .nrfd_i  (nrfd_w),
        .ndac_i  (ndac_w),
        .dio_n_o (dio_n_i),
        .atn_n_o (atn_n_i),
        .ifc_n_o (ifc_n_i),
        .ren_n_o (ren_n_i),
        .eoi_n_o (eoi_n_i),
        .dav_n_o (dav_n_i)
    );

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic print_verdict;
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    // Data bytes that should be taken are noted before they are sent.
    task automatic send(input logic atn, input logic eoi,
                        input logic [7:0] b, input logic acc);
        logic ok;
        if (!atn && acc) exp_q.push_back({eoi, b});
        ctl.xfer(atn, eoi, b, ok);
        chk("taken", {8'h00, acc}, {8'h00, ok});
    endtask : send

    task automatic drain;
        for (int n = 0; n < 300 && exp_q.size() != 0; n++) cyc(1);
        chk("drain", 9'h000, 9'(exp_q.size()));
    endtask : drain

    // Random stalls on the consumer side while bytes keep arriving.
    always @(posedge clk_i) begin
        #1 chr_ready_i = rnd_en ? 1'($random(seed)) : 1'b0;
    end

    // Output watcher: counts pulses and retires the oldest noted char.
    always @(posedge clk_i) begin
        if (trigger_o === 1'b1) n_trig <= n_trig + 1;
        if (dev_clear_o === 1'b1) n_clr <= n_clr + 1;
        if (chr_valid_o === 1'b1 && chr_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_checks++;
                failures++;
                $display("mismatch chr expected none seen %h", chr_o);
            end else begin
                chk("chr", exp_q.pop_front(), chr_o);
            end
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        #1 rst_i = 1'b0;
        chk("status", 9'h000, {4'h0, st});
        chk("oe", 9'h007, {6'h00, oe_w});
        send(1'b0, 1'b0, 8'h41, 1'b0);
        send(1'b1, 1'b0, 8'h3F, 1'b1);
        send(1'b1, 1'b0, {3'h1, pa_i}, 1'b1);
        chk("listen", 9'h010, {4'h0, st});
        send(1'b0, 1'b0, 8'h46, 1'b1);
        send(1'b0, 1'b0, 8'h30, 1'b1);
        send(1'b0, 1'b1, 8'h58, 1'b1);
        send(1'b1, 1'b0, 8'hBF, 1'b1);
        chk("unlisten", 9'h000, {4'h0, st});
        send(1'b1, 1'b0, 8'h3B, 1'b1);
        send(1'b1, 1'b0, {3'h2, pa_i}, 1'b1);
        send(1'b1, 1'b0, 8'h7B, 1'b1);
        send(1'b1, 1'b0, 8'h15, 1'b1);
        chk("talker", 9'h018, {4'h0, st});
        send(1'b1, 1'b0, 8'h45, 1'b1);
        chk("other_talk", 9'h010, {4'h0, st});
        ctl.lines(1'b1, 1'b0);
        cyc(5);
        chk("remote", 9'h014, {4'h0, st});
        send(1'b1, 1'b0, {1'b0, GCD_LLO}, 1'b1);
        chk("lockout", 9'h016, {4'h0, st});
        send(1'b1, 1'b0, {1'b0, GCD_GTL}, 1'b1);
        chk("local", 9'h000, {8'h00, remote_o});
        send(1'b1, 1'b0, {1'b0, GCD_GET}, 1'b1);
        send(1'b1, 1'b0, {1'b0, GCD_SDC}, 1'b1);
        send(1'b1, 1'b0, 8'h3F, 1'b1);
        ctl.lines(1'b0, 1'b0);
        ctl.lines(1'b1, 1'b0);
        cyc(4);
        send(1'b1, 1'b0, {1'b0, GCD_GTL}, 1'b1);
        chk("gtl_unaddr", 9'h001, {8'h00, remote_o});
        send(1'b1, 1'b0, {1'b0, GCD_GET}, 1'b1);
        send(1'b1, 1'b0, {1'b0, GCD_SDC}, 1'b1);
        send(1'b1, 1'b0, {1'b0, GCD_DCL}, 1'b1);
        cyc(2);
        chk("triggers", 9'h001, 9'(n_trig));
        chk("clears", 9'h002, 9'(n_clr));
        svc_req_i = 1'b1;
        cyc(1);
        svc_req_i = 1'b0;
        cyc(6);
        chk("srq_held", 9'h000, {7'h00, srq_out_o, srq_oe_n_o});
        send(1'b1, 1'b0, {1'b0, GCD_SPE}, 1'b1);
        chk("spoll_on", 9'h001, {8'h00, spoll_o});
        chk("srq_wait", 9'h000, {8'h00, srq_oe_n_o});
        send(1'b1, 1'b0, 8'h5B, 1'b1);
        cyc(2);
        chk("srq_done", 9'h001, {8'h00, srq_oe_n_o});
        send(1'b1, 1'b0, {1'b0, GCD_SPD}, 1'b1);
        chk("spoll_off", 9'h000, {8'h00, spoll_o});
        send(1'b1, 1'b0, 8'h3B, 1'b1);
        ctl.lines(1'b1, 1'b1);
        cyc(4);
        ctl.lines(1'b1, 1'b0);
        cyc(3);
        chk("ifc", 9'h000, {7'h00, listen_o, talk_o});
        drain();
        // Fill the buffer with the consumer stalled, then drain at random.
        rnd_en = 1'b0;
        send(1'b1, 1'b0, 8'h3B, 1'b1);
        repeat (5) send(1'b0, 1'($random(seed)), 8'($random(seed)), 1'b1);
        cyc(6);
        chk("full", 9'h000, {8'h00, nrfd_oe_n_o});
        rnd_en = 1'b1;
        repeat (8) send(1'b0, 1'($random(seed)), 8'($random(seed)), 1'b1);
        drain();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
